/* File: hdl/rtc_irq_map.vh */
`ifndef RTC_IRQ_MAP_VH
`define RTC_IRQ_MAP_VH

// Register offsets (4-bit address, 8-bit data)
`define ADDR_IRQ_CTRL 4'h0
`define ADDR_TIMER_CTRL 4'h1
`define ADDR_TIMER_PRESET 4'h2
`define ADDR_ALARM_MIN 4'h3
`define ADDR_ALARM_HOUR 4'h4
`define ADDR_ALARM_DAY 4'h5
`define ADDR_ALARM_WDAY 4'h6

// Interrupt control register fields
`define BIT_TIMER_IRQ_ENABLE 0
`define BIT_ALARM_IRQ_ENABLE 1
`define BIT_TIMER_FLAG 2
`define BIT_ALARM_FLAG 3
`define BIT_PULSE_REPEAT_MODE 4

// Timer control register fields
`define BIT_SRC_SEL_LO 0
`define BIT_SRC_SEL_HI 1
`define BIT_TIMER_ENABLE 7

// Alarm register fields
`define BIT_ALARM_FIELD_IGNORE 7

// Source clock select codes
`define SRC_4096HZ 2'h0
`define SRC_64HZ 2'h1
`define SRC_1HZ 2'h2
`define SRC_1_60HZ 2'h3

// Reset values
`define RST_IRQ_CTRL 8'h00
`define RST_TIMER_CTRL 8'h00
`define RST_TIMER_PRESET 8'h00
`define RST_ALARM 8'h80

// Timing
`define CLK_HZ 100000000
`define FAST_SRC_HZ 4096
// Clock cycles per 4096 Hz tick; the small rate error is accepted
`define FAST_DIV 15'h5f5e
`define DIV_64_FROM_FAST 6'h3f
`define DIV_1_FROM_64 6'h3f
`define DIV_MIN_FROM_SEC 6'h3b
// Auto-release low time in 4096 Hz periods
`define AUTO_RELEASE_PERIOD 8'h20

`endif

/* File: hdl/rtc_timer_alarm_irq.v */
// Function
// R1 - Two-bit select picks 4096/64/1/1-60 Hz source
// R2 - Interval is source period times preset
// R3 - First interval short by up to one period
// R4 - Countdown loads preset on enable rising
// R5 - Decrement per source tick; event at 01h-to-00h
// R6 - Event sets timer flag until host clears
// R7 - Disabling timer keeps flag and pin
// R8 - Level mode: event drives pin if enabled
// R9 - Level mode: enable bit gates pin while flagged
// R10 - Level mode: flag clear releases the pin
// R11 - Reload after each event while enabled
// R12 - After clear, next event sets flag again
// R13 - Repeat mode reloads and resumes automatically
// R14 - Repeat mode: fixed low pulse, then release
// R15 - Repeat mode: flag clear keeps pulse going
// R16 - Enable falling stops the countdown
// R17 - Host writes preset while timer disabled
// R18 - Host clears enable, flag, irq enable
// R19 - Alarm match sets sticky alarm flag
// R20 - Alarm enabled drives pin, no auto-release
// R21 - Alarm enable cleared releases pin
// R22 - Alarm flag cleared releases pin
// R23 - Ignore bits exclude fields; all ignored none
// R24 - Level mode: enable rising while flagged asserts
// R25 - Writing 1 to flags does nothing
// R26 - Shared pin low when either source asserts
// R27 - Alarm fires on entering match only
`timescale 1ns/1ps
`include "rtc_irq_map.vh"

module rtc_timer_alarm_irq #(
	parameter [14:0] FAST_DIV = `FAST_DIV
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Register port
	input wire [3:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_i,
	input wire rd_i,
	output wire [7:0] rd_data_o,
	// Current time from the calendar
	input wire [6:0] minute_i,
	input wire [5:0] hour_i,
	input wire [5:0] day_i,
	input wire [2:0] weekday_i,
	// Shared open-drain interrupt pin
	output wire irq_pin_n_o,
	output wire irq_pin_n_oe_n_o
);

	////////////////////////////////////////////////////////////////////////
	// Divider chain

	reg [14:0] div_q;
	reg tick4096_q;
	wire tick64;
	wire tick1;
	wire tick60;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_q <= 15'h0000;
			tick4096_q <= 1'b0;
		end
		else if (div_q == FAST_DIV - 15'h0001)
		begin
			div_q <= 15'h0000;
			tick4096_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 15'h0001;
			tick4096_q <= 1'b0;
		end
	end

	// Slower rates are single-cycle enables derived from the fast tick
	rate_step #(
		.LAST(`DIV_64_FROM_FAST)
	) step64_u (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(tick4096_q),
		.tick_o(tick64)
	);

	rate_step #(
		.LAST(`DIV_1_FROM_64)
	) step1_u (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(tick64),
		.tick_o(tick1)
	);

	// Minute tick runs from reset, not from the timer start
	rate_step #(
		.LAST(`DIV_MIN_FROM_SEC)
	) step60_u (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(tick1),
		.tick_o(tick60)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers

	reg timer_irq_enable_q;
	reg alarm_irq_enable_q;
	reg pulse_repeat_mode_q;
	reg timer_enable_q;
	reg [1:0] src_sel_q;
	reg [7:0] preset_q;
	reg [7:0] alarm_min_q;
	reg [7:0] alarm_hour_q;
	reg [7:0] alarm_day_q;
	reg [7:0] alarm_wday_q;
	reg timer_flag_q;
	reg alarm_flag_q;
	reg [7:0] count_q;
	reg [7:0] rd_data_q;

	wire wr_irq_ctrl;
	wire wr_timer_ctrl;

	assign wr_irq_ctrl = wr_i && (addr_i == `ADDR_IRQ_CTRL);
	assign wr_timer_ctrl = wr_i && (addr_i == `ADDR_TIMER_CTRL);

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			timer_irq_enable_q <= 1'b0;
			alarm_irq_enable_q <= 1'b0;
			pulse_repeat_mode_q <= 1'b0;
			timer_enable_q <= 1'b0;
			src_sel_q <= `SRC_4096HZ;
			preset_q <= `RST_TIMER_PRESET;
			alarm_min_q <= `RST_ALARM;
			alarm_hour_q <= `RST_ALARM;
			alarm_day_q <= `RST_ALARM;
			alarm_wday_q <= `RST_ALARM;
		end
		else if (wr_i)
		begin
			case (addr_i)
				`ADDR_IRQ_CTRL:
				begin
					timer_irq_enable_q <= wr_data_i[`BIT_TIMER_IRQ_ENABLE];
					alarm_irq_enable_q <= wr_data_i[`BIT_ALARM_IRQ_ENABLE];
					pulse_repeat_mode_q <= wr_data_i[`BIT_PULSE_REPEAT_MODE];
				end
				`ADDR_TIMER_CTRL:
				begin
					timer_enable_q <= wr_data_i[`BIT_TIMER_ENABLE];
					src_sel_q <= wr_data_i[`BIT_SRC_SEL_HI:`BIT_SRC_SEL_LO];
				end
				`ADDR_TIMER_PRESET: preset_q <= wr_data_i;
				`ADDR_ALARM_MIN: alarm_min_q <= wr_data_i;
				`ADDR_ALARM_HOUR: alarm_hour_q <= wr_data_i;
				`ADDR_ALARM_DAY: alarm_day_q <= wr_data_i;
				`ADDR_ALARM_WDAY: alarm_wday_q <= wr_data_i;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fixed-cycle timer

	reg src_tick;
	reg timer_event;
	wire timer_start;

	always @*
	begin
		case (src_sel_q) // R1
			`SRC_4096HZ: src_tick = tick4096_q;
			`SRC_64HZ: src_tick = tick64;
			`SRC_1HZ: src_tick = tick1;
			`SRC_1_60HZ: src_tick = tick60;
			default: src_tick = 1'b0;
		endcase
	end

	// Write of enable 0->1 starts; ticks run free, so first period is short
	assign timer_start = wr_timer_ctrl && wr_data_i[`BIT_TIMER_ENABLE] && !timer_enable_q; // R4 R3

	always @*
	begin
		timer_event = timer_enable_q && src_tick && (count_q == 8'h01); // R5 R2
	end

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			count_q <= 8'h00;
		else if (timer_start)
			count_q <= preset_q; // R4
		else if (timer_enable_q && src_tick)
		begin
			if (count_q == 8'h01)
				count_q <= preset_q; // R11 R13
			else if (count_q != 8'h00)
				count_q <= count_q - 8'h01; // R5
		end
		// Count freezes once enable drops
	end // R16

	// Flag is sticky; set wins over a clear in the same cycle
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			timer_flag_q <= 1'b0;
		else if (timer_event)
			timer_flag_q <= 1'b1; // R6 R12
		else if (wr_irq_ctrl && !wr_data_i[`BIT_TIMER_FLAG])
			timer_flag_q <= 1'b0; // R25 R7
	end

	// Auto-release pulse timer for repeat mode, counted in 4096 Hz periods
	reg [7:0] release_q;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			release_q <= 8'h00;
		else if (timer_event && pulse_repeat_mode_q && timer_irq_enable_q)
			release_q <= `AUTO_RELEASE_PERIOD; // R14
		else if (tick4096_q && release_q != 8'h00)
			release_q <= release_q - 8'h01; // R14 R15
	end

	wire timer_req;

	// Level mode follows flag and enable; repeat mode only the pulse
	assign timer_req = pulse_repeat_mode_q ? (release_q != 8'h00)
		: (timer_flag_q && timer_irq_enable_q); // R8 R9 R10 R24

	////////////////////////////////////////////////////////////////////////
	// Alarm

	wire min_ok;
	wire hour_ok;
	wire day_ok;
	wire wday_ok;
	wire all_ignored;
	wire alarm_match;
	reg match_prev_q;

	assign min_ok = alarm_min_q[`BIT_ALARM_FIELD_IGNORE] || (alarm_min_q[6:0] == minute_i); // R23
	assign hour_ok = alarm_hour_q[`BIT_ALARM_FIELD_IGNORE] || (alarm_hour_q[5:0] == hour_i); // R23
	assign day_ok = alarm_day_q[`BIT_ALARM_FIELD_IGNORE] || (alarm_day_q[5:0] == day_i); // R23
	assign wday_ok = alarm_wday_q[`BIT_ALARM_FIELD_IGNORE] || (alarm_wday_q[2:0] == weekday_i); // R23
	assign all_ignored = alarm_min_q[`BIT_ALARM_FIELD_IGNORE] && alarm_hour_q[`BIT_ALARM_FIELD_IGNORE]
		&& alarm_day_q[`BIT_ALARM_FIELD_IGNORE] && alarm_wday_q[`BIT_ALARM_FIELD_IGNORE];
	assign alarm_match = min_ok && hour_ok && day_ok && wday_ok && !all_ignored; // R19 R23

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			match_prev_q <= 1'b0;
			alarm_flag_q <= 1'b0;
		end
		else
		begin
			match_prev_q <= alarm_match;
			if (alarm_match && !match_prev_q)
				alarm_flag_q <= 1'b1; // R19 R27
			else if (wr_irq_ctrl && !wr_data_i[`BIT_ALARM_FLAG])
				alarm_flag_q <= 1'b0; // R22 R25
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin and read data

	reg pin_oe_n_q;
	reg pin_q;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_oe_n_q <= 1'b1;
			pin_q <= 1'b0;
		end
		else
		begin
			pin_q <= 1'b0;
			// Alarm level never self-releases
			pin_oe_n_q <= !(timer_req || (alarm_flag_q && alarm_irq_enable_q)); // R26 R20 R21
		end
	end

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_q <= 8'h00;
		else if (rd_i)
		begin
			case (addr_i)
				`ADDR_IRQ_CTRL: rd_data_q <= {3'h0, pulse_repeat_mode_q, alarm_flag_q, timer_flag_q,
					alarm_irq_enable_q, timer_irq_enable_q};
				`ADDR_TIMER_CTRL: rd_data_q <= {timer_enable_q, 5'h00, src_sel_q};
				// Live count; may change between reads
				`ADDR_TIMER_PRESET: rd_data_q <= count_q;
				`ADDR_ALARM_MIN: rd_data_q <= alarm_min_q;
				`ADDR_ALARM_HOUR: rd_data_q <= {alarm_hour_q[7], 1'b0, alarm_hour_q[5:0]};
				`ADDR_ALARM_DAY: rd_data_q <= {alarm_day_q[7], 1'b0, alarm_day_q[5:0]};
				`ADDR_ALARM_WDAY: rd_data_q <= {alarm_wday_q[7], 4'h0, alarm_wday_q[2:0]};
				default: rd_data_q <= 8'h00;
			endcase
		end
		else
			rd_data_q <= 8'h00;
	end

	assign rd_data_o = rd_data_q;
	assign irq_pin_n_o = pin_q;
	assign irq_pin_n_oe_n_o = pin_oe_n_q;

endmodule // rtc_timer_alarm_irq

////////////////////////////////////////////////////////////////////////
// One divider stage; pulses for one cycle per wrap of its count

module rate_step #(
	parameter [5:0] LAST = 6'h3f
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Rate ticks
	input wire tick_i,
	output wire tick_o
);

	// Wrap value is the input ticks per output tick minus one
	reg [5:0] cnt_q;
	reg tick_q;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end
		else if (tick_i && cnt_q == LAST)
		begin
			cnt_q <= 6'h00;
			tick_q <= 1'b1;
		end
		else
		begin
			if (tick_i)
				cnt_q <= cnt_q + 6'h01;
			tick_q <= 1'b0;
		end
	end

	// Registered pulse keeps the next stage one cycle behind
	assign tick_o = tick_q;

endmodule // rate_step

/* File: test/irq_line_model.sv */
`timescale 1ns/1ps
module irq_line_model (
	// Pin from the block
	input wire irq_pin_n_i,
	input wire irq_pin_n_oe_n_i,
	// Level the host sees
	output wire irq_line_o
);
	// Pull-up wins once released, never a stale low
	assign irq_line_o = irq_pin_n_oe_n_i ? 1'b1 : irq_pin_n_i;
endmodule // irq_line_model

/* File: test/rtc_timer_alarm_irq_assertions.sv */
`timescale 1ns/1ps
module rtc_irq_checker (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Register port
	input wire [3:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rd_data_o,
	// Pin
	input wire irq_pin_n_o,
	input wire irq_pin_n_oe_n_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// Read data and pin both lag the registers by one cycle
	sequence s_rd0;
		$past(rd_i) && $past(addr_i) == 4'h0;
	endsequence
	property p_rd_idle;
		!$past(rd_i) |-> rd_data_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		$past(rd_i) && $past(addr_i) > 4'h6 |-> rd_data_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_unused;
		$past(rd_i) && $past(addr_i) == 4'h1 |-> rd_data_o[6:2] == 5'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bits set");
	property p_pin_data;
		irq_pin_n_o == 1'b0;
	endproperty
	a_pin_data: assert property (p_pin_data) else $error("pin drives high");
	property p_timer_low;
		s_rd0 ##0 (rd_data_o & 8'h15) == 8'h05 |-> !irq_pin_n_oe_n_o;
	endproperty
	a_timer_low: assert property (p_timer_low) else $error("timer pin not low");
	property p_alarm_low;
		s_rd0 ##0 (rd_data_o & 8'h0a) == 8'h0a |-> !irq_pin_n_oe_n_o;
	endproperty
	a_alarm_low: assert property (p_alarm_low) else $error("alarm pin not low");
	property p_level_high;
		s_rd0 ##0 (!rd_data_o[4] && (rd_data_o & 8'h05) != 8'h05 && (rd_data_o & 8'h0a) != 8'h0a)
			|-> irq_pin_n_oe_n_o;
	endproperty
	a_level_high: assert property (p_level_high) else $error("pin not released");
	property p_wr_release;
		wr_i && addr_i == 4'h0 && (wr_data_i & 8'h11) == 8'h00 && (wr_data_i & 8'h0a) != 8'h0a
			|-> ##2 irq_pin_n_oe_n_o;
	endproperty
	a_wr_release: assert property (p_wr_release) else $error("write left pin low");
endmodule // rtc_irq_checker
bind rtc_timer_alarm_irq rtc_irq_checker chk_u (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.addr_i(addr_i),
	.wr_data_i(wr_data_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rd_data_o(rd_data_o),
	.irq_pin_n_o(irq_pin_n_o),
	.irq_pin_n_oe_n_o(irq_pin_n_oe_n_o)
);

/* File: test/rtc_timer_alarm_irq_bench.sv */
`timescale 1ns/1ps
module rtc_timer_alarm_irq_bench;
	reg clock_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] addr_i = 4'h0;
	reg [7:0] wr_data_i = 8'h00;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg [6:0] minute_i = 7'h00;
	reg [5:0] hour_i = 6'h00;
	reg [5:0] day_i = 6'h00;
	reg [2:0] weekday_i = 3'h0;
	reg [6:0] m;
	reg [5:0] h;
	wire [7:0] rd_data_o;
	wire irq_pin_n_o;
	wire irq_pin_n_oe_n_o;
	wire irq_line;
	reg rd_seen = 1'b0;
	reg [7:0] exp_q[$];
	reg [7:0] msk_q[$];
	integer errors = 0;
	integer n_tests = 0;
	integer cycles = 0;
	integer n, i, s, p, q;
	always #5 clock_i = ~clock_i;
	// Short divider keeps the 1 Hz case inside the run budget
	rtc_timer_alarm_irq #(.FAST_DIV(15'h0004)) dut_u (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.wr_data_i(wr_data_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rd_data_o(rd_data_o),
		.minute_i(minute_i),
		.hour_i(hour_i),
		.day_i(day_i),
		.weekday_i(weekday_i),
		.irq_pin_n_o(irq_pin_n_o),
		.irq_pin_n_oe_n_o(irq_pin_n_oe_n_o)
	);
	irq_line_model line_u (
		.irq_pin_n_i(irq_pin_n_o),
		.irq_pin_n_oe_n_i(irq_pin_n_oe_n_o),
		.irq_line_o(irq_line)
	);
	////////////////////////////////////////
	task check(input string nm, input [7:0] seen, input [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [3:0] a, input [7:0] e, input [7:0] k);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		exp_q.push_back(e & k);
		msk_q.push_back(k);
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask
	task wait_for(input lvl, input integer max);
		n = 0;
		while (irq_line !== lvl && n < max)
		begin
			@(posedge clock_i);
			n = n + 1;
		end
	endtask
	task hold(input integer k);
		repeat (k) @(posedge clock_i);
	endtask
	////////////////////////////////////////
	always @(posedge clock_i)
	begin
		if (rd_seen)
			check("rd_data", rd_data_o & msk_q.pop_front(), exp_q.pop_front());
		rd_seen <= rd_i;
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			errors = errors + 1;
			test_done;
		end
	end
	initial
	begin
		i = $urandom(78);
		hold(10);
		rst_i <= 1'b0;
		for (i = 0; i < 8; i = i + 1)
			rd(i == 7 ? 4'hf : i[3:0], (i > 2 && i < 7) ? 8'h80 : 8'h00, 8'hff);
		$display("test reset done");
		wr(4'h0, 8'h01);
		for (i = 0; i < 5; i = i + 1)
		begin
			s = i < 3 ? 0 : i - 2;
			p = s ? 2 : 1 + $urandom % 255;
			q = s == 0 ? 4 : s == 1 ? 256 : 16384;
			wr(4'h2, p[7:0]);
			wr(4'h1, 8'h80 | s[7:0]);
			wait_for(1'b0, p * q + 8);
			check("interval", n >= (p - 1) * q && n <= p * q + 4, 8'h01);
			if (s < 2)
			begin
				wr(4'h0, 8'h01);
				hold(3);
				if (p > 2)
					check("cleared", irq_line, 8'h01);
				wait_for(1'b0, p * q + 8);
				check("reload", n >= p * q - 8 && n <= p * q + 4, 8'h01);
			end
			wr(4'h1, 8'h00);
			hold(4);
			check("held", irq_line, 8'h00);
			wr(4'h0, 8'h04);
			hold(3);
			check("tie off", irq_line, 8'h01);
			wr(4'h0, 8'h05);
			hold(3);
			check("tie on", irq_line, 8'h00);
			rd(4'h0, 8'h05, 8'h1f);
			wr(4'h0, 8'h01);
			hold(3);
			check("released", irq_line, 8'h01);
		end
		wr(4'h2, 8'h01);
		wr(4'h1, 8'h83);
		hold(5000);
		check("minute", irq_line, 8'h01);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h05);
		rd(4'h0, 8'h01, 8'h1f);
		$display("test timer done");
		wr(4'h2, 8'h40);
		wr(4'h0, 8'h11);
		wr(4'h1, 8'h80);
		wait_for(1'b0, 270);
		wr(4'h0, 8'h11);
		wait_for(1'b1, 200);
		check("pulse", n >= 120 && n <= 134, 8'h01);
		wait_for(1'b0, 200);
		check("repeat", n <= 140, 8'h01);
		wr(4'h1, 8'h00);
		wait_for(1'b1, 200);
		wr(4'h0, 8'h00);
		$display("test repeat done");
		m = $urandom;
		p = $urandom;
		h = p[5:0];
		minute_i <= m + 7'h01;
		hour_i <= h;
		day_i <= p[13:8];
		weekday_i <= p[18:16];
		wr(4'h3, {1'b0, m});
		wr(4'h4, {2'b00, h});
		wr(4'h0, 8'h02);
		minute_i <= m;
		hold(4);
		check("alarm", irq_line, 8'h00);
		rd(4'h0, 8'h0a, 8'h1f);
		wr(4'h0, 8'h02);
		hold(4);
		check("alarm clear", irq_line, 8'h01);
		rd(4'h0, 8'h02, 8'h1f);
		hour_i <= h + 6'h01;
		hold(2);
		hour_i <= h;
		hold(4);
		check("alarm again", irq_line, 8'h00);
		wr(4'h0, 8'h08);
		hold(3);
		check("alarm off", irq_line, 8'h01);
		rd(4'h0, 8'h08, 8'h1f);
		wr(4'h0, 8'h02);
		wr(4'h3, {1'b1, m});
		wr(4'h4, 8'h80);
		minute_i <= m + 7'h01;
		hold(2);
		minute_i <= m;
		hold(4);
		rd(4'h0, 8'h02, 8'h1f);
		$display("test alarm done");
		test_done;
	end
endmodule // rtc_timer_alarm_irq_bench
